// >>> pkg/pwrseq_map.vh
// constants for the power key sequencer
`ifndef PWRSEQ_MAP_VH
`define PWRSEQ_MAP_VH
`define CLK_HZ 10000000
`define ON_HOLD_MS 500
`define OFF_HOLD_MS 650
`define CYC_PER_MS (`CLK_HZ / 1000)
`define ON_HOLD_CYC (`ON_HOLD_MS * `CYC_PER_MS)
`define OFF_HOLD_CYC (`OFF_HOLD_MS * `CYC_PER_MS)
`define SHUT_MS 10
`define SHUT_CYC (`SHUT_MS * `CYC_PER_MS)
`define BOOT_MS 10
`define BOOT_CYC (`BOOT_MS * `CYC_PER_MS)
`define ST_OFF 3'h0
`define ST_BOOT 3'h1
`define ST_RUN 3'h2
`define ST_SHUT 3'h3
`define ST_DL 3'h4
`define ST_WAITREL 3'h5
`endif

// >>> hw/low_timer.v
// counts continuous cycles of a low level and flags two thresholds
`timescale 1ns/1ns
module low_timer #(
  parameter WIDTH = 24
) (
  input wire clk,
  input wire rst,
  input wire level_n,
  input wire [WIDTH-1:0] thr_a,
  input wire [WIDTH-1:0] thr_b,
  output wire reached_a,
  output wire reached_b,
  output wire held
);
  reg [WIDTH-1:0] cnt_reg;
  // count while low, restart on any high; saturate
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= {WIDTH{1'b0}};
    end else if (level_n) begin
      cnt_reg <= {WIDTH{1'b0}};
    end else if (cnt_reg != {WIDTH{1'b1}}) begin
      cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
  assign reached_a = (cnt_reg >= thr_a);
  assign reached_b = (cnt_reg >= thr_b);
  assign held = ~level_n;
endmodule

// >>> hw/power_key_sequencer.v
// power key, restart and boot strap sequencing of the module
// Notes on behaviour
// - a key low for at least 500 ms while powered down starts the module.
// - a key held low at least 650 ms then released starts shutdown.
// - a software power-down command runs the same orderly shutdown.
// - if the key is low during command shutdown, shutdown waits until the key is released.
// - with the key tied low since power-up the command is ignored.
// - a hard restart needs the key pulled low while restart is already low.
// - a high boot strap sampled before turn-on selects download mode.
// - firmware upgrade over usb is allowed only in download mode.
// - the usb port is device only and offers high and full speed.
// - usb carries satellite sentences only in the integrated arrangement.
// - integrated arrangement switches the satellite supply internally.
`timescale 1ns/1ns
`include "pwrseq_map.vh"
module power_key_sequencer #(
  parameter CNT_W = 24,
  parameter ON_HOLD_CYC = `ON_HOLD_CYC,
  parameter OFF_HOLD_CYC = `OFF_HOLD_CYC,
  parameter SHUT_CYC = `SHUT_CYC,
  parameter BOOT_CYC = `BOOT_CYC
) (
  input wire CLOCK,
  input wire SYS_RST,
  input wire POWER_KEY_N,
  input wire RESTART_N,
  input wire BOOT_STRAP,
  input wire POWER_DOWN_COMMAND,
  input wire INTEGRATED_MODE,
  input wire UPGRADE_REQ,
  output reg IO_RAIL_OUT,
  output reg POWERED,
  output reg DOWNLOAD_MODE,
  output reg SHUTDOWN_DONE,
  output reg RESTART_PULSE,
  output reg UPGRADE_GRANT,
  output reg UPGRADE_REFUSED,
  output wire USB_DEVICE_ONLY,
  output wire USB_HS_CAPABLE,
  output wire USB_FS_CAPABLE,
  output reg USB_GNSS_SENTENCES_EN,
  output reg GNSS_SUPPLY_EN
);
  localparam [CNT_W-1:0] ON_THR = ON_HOLD_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] OFF_THR = OFF_HOLD_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] SHUT_THR = SHUT_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] BOOT_THR = BOOT_CYC[CNT_W-1:0];

  // one step of a cycle timer, kept at the timer width
  function [CNT_W-1:0] inc_cnt;
    input [CNT_W-1:0] value;
    begin
      inc_cnt = value + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // sequencer state and its cycle timer
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [CNT_W-1:0] tmr_reg;
  reg [CNT_W-1:0] tmr_next;
  // boot strap captured while off, and the tied key flag
  reg strap_reg;
  reg strap_next;
  reg tied_reg;
  reg tied_next;
  // key history used by the tied test and the edge detectors
  reg key_seen_high_reg;
  reg key_prev_reg;
  reg restart_arm_reg;
  reg off_hold_reg;
  // set when the running shutdown came from the command
  reg cmd_shut_reg;
  reg cmd_shut_next;
  // timer flags and key edges
  wire on_reached;
  wire off_reached;
  wire key_low;
  wire key_fall;
  wire key_rise;
  // next-state decodes shared by the output registers
  wire next_off;
  wire next_boot;
  wire next_run;
  wire next_dl;

  // continuous low time of the power key
  low_timer #(
    .WIDTH(CNT_W)
  ) u_key_timer (
    .clk(CLOCK),
    .rst(SYS_RST),
    .level_n(POWER_KEY_N),
    .thr_a(ON_THR),
    .thr_b(OFF_THR),
    .reached_a(on_reached),
    .reached_b(off_reached),
    .held(key_low)
  );

  assign key_fall = key_prev_reg & ~POWER_KEY_N;
  assign key_rise = ~key_prev_reg & POWER_KEY_N;

  // decode the coming state once for all outputs
  assign next_off = (state_next == `ST_OFF);
  assign next_boot = (state_next == `ST_BOOT);
  assign next_run = (state_next == `ST_RUN);
  assign next_dl = (state_next == `ST_DL);

  // usb capabilities are fixed
  assign USB_DEVICE_ONLY = 1'b1;
  assign USB_HS_CAPABLE = 1'b1;
  assign USB_FS_CAPABLE = 1'b1;

  // edge history, key-high history and restart arming
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      key_prev_reg <= 1'b1;
      key_seen_high_reg <= 1'b0;
      restart_arm_reg <= 1'b0;
    end else begin
      key_prev_reg <= POWER_KEY_N;
      if (POWER_KEY_N) begin
        key_seen_high_reg <= 1'b1;
      end
      // restart must be low before the key falls
      restart_arm_reg <= ~RESTART_N;
    end
  end

  // sequencer next state
  always @* begin
    state_next = state_reg;
    tmr_next = tmr_reg;
    strap_next = strap_reg;
    tied_next = tied_reg;
    cmd_shut_next = cmd_shut_reg;
    case (state_reg)
      // powered down: wait for a long enough key press
      `ST_OFF: begin
        tmr_next = {CNT_W{1'b0}};
        cmd_shut_next = 1'b0;
        // strap sampled while still powered down
        strap_next = BOOT_STRAP;
        if (on_reached) begin
          // key never released since reset means tied low
          tied_next = ~key_seen_high_reg;
          state_next = `ST_BOOT;
        end
      end
      // fixed boot time before any mode is entered
      `ST_BOOT: begin
        tmr_next = inc_cnt(tmr_reg);
        if (tmr_reg >= BOOT_THR) begin
          tmr_next = {CNT_W{1'b0}};
          state_next = `ST_WAITREL;
        end
      end
      `ST_WAITREL: begin
        // the turn-on press must end before a turn-off can count
        if (!key_low || tied_reg) begin
          state_next = strap_reg ? `ST_DL : `ST_RUN;
        end
      end
      // running: restart, key turn-off or command turn-off
      `ST_RUN, `ST_DL: begin
        if (key_fall && restart_arm_reg) begin
          state_next = `ST_BOOT;
          tmr_next = {CNT_W{1'b0}};
          strap_next = BOOT_STRAP;
        end else if (key_rise && off_hold_reg) begin
          state_next = `ST_SHUT;
          cmd_shut_next = 1'b0;
        end else if (POWER_DOWN_COMMAND && !tied_reg) begin
          state_next = `ST_SHUT;
          cmd_shut_next = 1'b1;
        end
      end
      // orderly shutdown, stalled by a low key after a command
      `ST_SHUT: begin
        if (cmd_shut_reg && key_low) begin
          // key low stalls a command shutdown
          tmr_next = {CNT_W{1'b0}};
        end else begin
          tmr_next = inc_cnt(tmr_reg);
        end
        if (tmr_reg >= SHUT_THR) begin
          tmr_next = {CNT_W{1'b0}};
          state_next = `ST_OFF;
        end
      end
      default: begin
        state_next = `ST_OFF;
      end
    endcase
  end

  // remembers that the key reached the turn-off hold during this press
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      off_hold_reg <= 1'b0;
    end else if (POWER_KEY_N) begin
      off_hold_reg <= 1'b0;
    end else if (off_reached) begin
      off_hold_reg <= 1'b1;
    end
  end

  // state registers
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= `ST_OFF;
      tmr_reg <= {CNT_W{1'b0}};
      strap_reg <= 1'b0;
      tied_reg <= 1'b0;
      cmd_shut_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      strap_reg <= strap_next;
      tied_reg <= tied_next;
      cmd_shut_reg <= cmd_shut_next;
    end
  end

  // rail and mode outputs follow the coming state
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      IO_RAIL_OUT <= 1'b0;
      POWERED <= 1'b0;
      DOWNLOAD_MODE <= 1'b0;
    end else begin
      IO_RAIL_OUT <= ~next_off;
      POWERED <= next_run | next_dl;
      DOWNLOAD_MODE <= next_dl;
    end
  end

  // shutdown completion and restart marker
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SHUTDOWN_DONE <= 1'b0;
      RESTART_PULSE <= 1'b0;
    end else begin
      // high while off after a completed shutdown, safe to cut supply
      if (state_reg == `ST_SHUT && next_off) begin
        SHUTDOWN_DONE <= 1'b1;
      end else if (!next_off) begin
        SHUTDOWN_DONE <= 1'b0;
      end
      // a restart is a jump back to boot from a running mode
      RESTART_PULSE <= (state_reg != `ST_BOOT) &&
        (state_reg != `ST_OFF) && next_boot;
    end
  end

  // upgrade answer, refused outside download mode
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      UPGRADE_GRANT <= 1'b0;
      UPGRADE_REFUSED <= 1'b0;
    end else begin
      UPGRADE_GRANT <= UPGRADE_REQ && next_dl;
      UPGRADE_REFUSED <= UPGRADE_REQ && !next_dl;
    end
  end

  // satellite outputs exist only in the integrated arrangement
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      USB_GNSS_SENTENCES_EN <= 1'b0;
      GNSS_SUPPLY_EN <= 1'b0;
    end else begin
      // sentences only while running normally
      USB_GNSS_SENTENCES_EN <= INTEGRATED_MODE && next_run;
      // supply switched inside while powered in any mode
      GNSS_SUPPLY_EN <= INTEGRATED_MODE && (next_run || next_dl);
    end
  end
endmodule

// >>> sim/pks_props.sv
// checker of the power key sequencer port relations
`timescale 1ns/1ns
module pks_props #(
  parameter ON_HOLD_CYC = 20
) (
  input wire CLOCK,
  input wire SYS_RST,
  input wire POWER_KEY_N,
  input wire RESTART_N,
  input wire INTEGRATED_MODE,
  input wire UPGRADE_REQ,
  input wire IO_RAIL_OUT,
  input wire POWERED,
  input wire DOWNLOAD_MODE,
  input wire SHUTDOWN_DONE,
  input wire RESTART_PULSE,
  input wire UPGRADE_GRANT,
  input wire UPGRADE_REFUSED,
  input wire USB_DEVICE_ONLY,
  input wire USB_HS_CAPABLE,
  input wire USB_FS_CAPABLE,
  input wire USB_GNSS_SENTENCES_EN,
  input wire GNSS_SUPPLY_EN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  reg [23:0] low_cnt_reg;
  // counts consecutive low samples of the key
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST || POWER_KEY_N) low_cnt_reg <= 24'h000000;
    else low_cnt_reg <= low_cnt_reg + 24'h000001;
  end
  chk_on_hold: assert property ($rose(IO_RAIL_OUT) |->
    low_cnt_reg >= ON_HOLD_CYC - 1) else $error("turn-on too early");
  chk_rail_pow: assert property (POWERED |-> IO_RAIL_OUT)
    else $error("powered without rail");
  chk_dl_pow: assert property (DOWNLOAD_MODE |-> POWERED)
    else $error("download while off");
  chk_grant_dl: assert property (UPGRADE_GRANT |->
    $past(UPGRADE_REQ) && DOWNLOAD_MODE) else $error("bad grant");
  chk_refuse_out: assert property (UPGRADE_REFUSED |->
    $past(UPGRADE_REQ) && !DOWNLOAD_MODE) else $error("bad refusal");
  chk_sentence_run: assert property (USB_GNSS_SENTENCES_EN |->
    POWERED && !DOWNLOAD_MODE) else $error("sentences outside run");
  chk_usb_fixed: assert property (USB_DEVICE_ONLY && USB_HS_CAPABLE
    && USB_FS_CAPABLE) else $error("usb ability lost");
  chk_gnss_sup: assert property (GNSS_SUPPLY_EN |->
    $past(INTEGRATED_MODE)) else $error("gnss supply in separate mode");
  chk_restart_cause: assert property (RESTART_PULSE |->
    $past(!RESTART_N)) else $error("restart without restart input");
  chk_shut_off: assert property ($rose(SHUTDOWN_DONE) |->
    !IO_RAIL_OUT && !POWERED) else $error("shutdown left rail up");
endmodule
bind power_key_sequencer pks_props #(.ON_HOLD_CYC(ON_HOLD_CYC)) i_pks_props (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .POWER_KEY_N(POWER_KEY_N),
  .RESTART_N(RESTART_N), .INTEGRATED_MODE(INTEGRATED_MODE),
  .UPGRADE_REQ(UPGRADE_REQ), .IO_RAIL_OUT(IO_RAIL_OUT), .POWERED(POWERED),
  .DOWNLOAD_MODE(DOWNLOAD_MODE), .SHUTDOWN_DONE(SHUTDOWN_DONE),
  .RESTART_PULSE(RESTART_PULSE), .UPGRADE_GRANT(UPGRADE_GRANT),
  .UPGRADE_REFUSED(UPGRADE_REFUSED), .USB_DEVICE_ONLY(USB_DEVICE_ONLY),
  .USB_HS_CAPABLE(USB_HS_CAPABLE), .USB_FS_CAPABLE(USB_FS_CAPABLE),
  .USB_GNSS_SENTENCES_EN(USB_GNSS_SENTENCES_EN),
  .GNSS_SUPPLY_EN(GNSS_SUPPLY_EN));

// >>> sim/host_model.sv
// host model driving key, restart, strap and command pins
`timescale 1ns/1ns
module host_model #(
  parameter SETTLE_CYC = 3
) (
  input wire clk,
  output reg key_n,
  output reg restart_n,
  output reg strap,
  output reg cmd
);
  // supply is only dropped by the bench after a shutdown
  initial begin
    key_n = 1'b1;
    restart_n = 1'b1;
    strap = 1'b0;
    cmd = 1'b0;
  end
  // wait for a settled supply, then hold the key low n cycles
  task press(input integer n, input reg s);
    begin
      strap = s;
      repeat (SETTLE_CYC) @(posedge clk);
      #5 key_n = 1'b0;
      repeat (n) @(posedge clk);
      #5 key_n = 1'b1;
    end
  endtask
  // restart input goes low SETTLE_CYC + 1 cycles ahead of the key
  task restart(input integer n);
    begin
      restart_n = 1'b0;
      @(posedge clk);
      press(n, strap);
      restart_n = 1'b1;
    end
  endtask
  // command pulse; a nonzero n pulls the key low n + 1 cycles, zero leaves it
  task command(input integer n);
    begin
      cmd = 1'b1;
      if (n != 0) key_n = 1'b0;
      @(posedge clk);
      #5 cmd = 1'b0;
      if (n != 0) begin
        repeat (n) @(posedge clk);
        #5 key_n = 1'b1;
      end
    end
  endtask
  task tie_low;
    key_n = 1'b0;
  endtask
endmodule

// >>> sim/module_power_key_sequencer_bench.sv
// self-checking bench of the power key sequencer
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("Error %0t: value mismatch", $time); end end
module module_power_key_sequencer_bench;
  localparam ON = 20, OFF = 26, SH = 5, BT = 5;
  reg CLOCK = 0, SYS_RST = 1, INTEGRATED_MODE = 0, UPGRADE_REQ = 0;
  wire kn, rn, st, cm, rail, pow, dl, done, rp, gr, rf, dv, hs, fs, se, gs;
  integer err_count = 0, tests_run = 0, cyc = 0, k, seen;
  always #50 CLOCK = ~CLOCK;
  host_model i_host_model (.clk(CLOCK), .key_n(kn), .restart_n(rn),
    .strap(st), .cmd(cm));
  power_key_sequencer #(.ON_HOLD_CYC(ON), .OFF_HOLD_CYC(OFF),
    .SHUT_CYC(SH), .BOOT_CYC(BT)) i_power_key_sequencer (.CLOCK(CLOCK),
    .SYS_RST(SYS_RST), .POWER_KEY_N(kn), .RESTART_N(rn), .BOOT_STRAP(st),
    .POWER_DOWN_COMMAND(cm), .INTEGRATED_MODE(INTEGRATED_MODE),
    .UPGRADE_REQ(UPGRADE_REQ), .IO_RAIL_OUT(rail), .POWERED(pow),
    .DOWNLOAD_MODE(dl), .SHUTDOWN_DONE(done), .RESTART_PULSE(rp),
    .UPGRADE_GRANT(gr), .UPGRADE_REFUSED(rf), .USB_DEVICE_ONLY(dv),
    .USB_HS_CAPABLE(hs), .USB_FS_CAPABLE(fs), .USB_GNSS_SENTENCES_EN(se),
    .GNSS_SUPPLY_EN(gs));
  task wrap_up;
    begin
      $display("tests %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up;
    end
  end
  task tick(input integer n);
    begin
      repeat (n) @(posedge CLOCK);
      #5;
    end
  endtask
  // bounded wait until rail and powered both equal v
  task settle(input reg v);
    for (k = 0; k < 60 && !(rail === v && pow === v); k++) tick(1);
  endtask
  // upgrade request answered one cycle later
  task upgrade(input reg g);
    begin
      UPGRADE_REQ = 1'b1;
      tick(2);
      `CHK({gr, rf}, {g, !g})
      UPGRADE_REQ = 1'b0;
    end
  endtask
  initial begin
    k = $urandom(32'h46CD6DCE);
    tick(3);
    SYS_RST = 1'b0;
    `CHK({rail, pow, dl, done, gs, dv, hs, fs}, 8'h07)
    i_host_model.press(ON - 3, 1'b0);
    tick(BT + 10);
    `CHK(rail, 1'b0)
    $display("short press test ended");
    INTEGRATED_MODE = $urandom;
    i_host_model.press(ON + 2, 1'b0);
    settle(1'b1);
    `CHK({dl, se, gs}, {1'b0, INTEGRATED_MODE, INTEGRATED_MODE})
    upgrade(1'b0);
    i_host_model.command(SH + 8);
    `CHK(rail, 1'b1)
    settle(1'b0);
    `CHK(done, 1'b1)
    $display("command shutdown test ended");
    i_host_model.press(ON + 2, 1'b1);
    settle(1'b1);
    `CHK({dl, gs, se}, {1'b1, INTEGRATED_MODE, 1'b0})
    upgrade(1'b1);
    seen = 0;
    fork
      i_host_model.restart(3);
      repeat (10) begin
        tick(1);
        if (rp === 1'b1) seen = 1;
      end
    join
    `CHK(seen, 1)
    settle(1'b1);
    i_host_model.press(OFF + 2, 1'b0);
    settle(1'b0);
    `CHK({done, dl}, 2'h2)
    $display("download and key shutdown test ended");
    SYS_RST = 1'b1;
    i_host_model.tie_low;
    tick(2);
    SYS_RST = 1'b0;
    tick(ON + BT + 10);
    i_host_model.command(0);
    tick(SH + 10);
    `CHK({rail, done}, 2'h2)
    $display("tied key test ended");
    wrap_up;
  end
endmodule
